// file: verilog/lut_ram_pkg.sv
// Shared constants and types for the distributed lookup-table RAM
package lut_ram_pkg;

	// Geometry of one lookup table
	localparam int RAM_ADDR_W = 4;
	localparam int RAM_DEPTH = 16;

	// Contents after configuration when no initial value is given
	localparam logic [15:0] RAM_INIT_DEFAULT = 16'h0000;

	// Control state after the synchronous reset
	localparam logic WCLK_PREV_RESET = 1'b1;
	localparam logic FLAG_RESET = 1'b0;

	// System clock period and the longest write clock high phase after an edge
	localparam int CLK_PERIOD_NS = 10;
	localparam int WCLK_PULSE_MAX_NS = 1000000;
	// Longest time rounds down to whole cycles
	localparam int WCLK_PULSE_MAX_CYC = WCLK_PULSE_MAX_NS / CLK_PERIOD_NS;

	// Operating forms of the cell
	typedef enum logic [1:0] {
		MODE_DUAL_EDGE,
		MODE_LEVEL_16X2,
		MODE_LEVEL_32X1,
		MODE_IDLE
	} ram_mode_t;

endpackage

// file: verilog/distributed_lut_ram.sv
// Logic cell RAM: dual-port edge-triggered and single-port level-sensitive forms
// Overview of operation
// - Dual-port form joins both tables into one 16x1 memory, one write, two reads.
// - Write and read may share a cycle, at different or identical addresses.
// - Dual-port writes are edge-triggered only; no level-sensitive write there.
// - Shared address reads and writes the first table; single-port output shows it.
// - Second table written at shared address, read at second read address.
// - Each dual-port write stores the data bit into both tables; strobe and clock gate it.
// - Level form writes while strobe is high, like a latch; later data overwrites.
// - Level form arranges as 16x2 or 32x1, with own data pins and outputs.
// - Contents load only at configuration from initial values, zero by default.
// - Chip-wide reset leaves the contents unchanged.
`timescale 1ns/1ps
`default_nettype none

module distributed_lut_ram
	import lut_ram_pkg::*;
#(
	parameter logic [RAM_DEPTH-1:0] INIT_F = RAM_INIT_DEFAULT,
	parameter logic [RAM_DEPTH-1:0] INIT_G = RAM_INIT_DEFAULT,
	parameter int WCLK_HIGH_MAX_CYC = WCLK_PULSE_MAX_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_config_load,
	input wire ram_mode_t i_mode,
	input wire logic [RAM_ADDR_W:0] i_addr,
	input wire logic [RAM_ADDR_W-1:0] i_second_read_address,
	input wire logic i_data_in_pin_a,
	input wire logic i_data_in_pin_b,
	input wire logic i_we,
	input wire logic i_wclk,
	output logic o_single_port_read_out,
	output logic o_dual_port_read_out,
	output logic o_write_ack,
	output logic o_wclk_overlong,
	output logic o_level_addr_hazard
);

	localparam int CNT_W = $clog2(WCLK_HIGH_MAX_CYC + 1);
	localparam logic [CNT_W-1:0] HOLD_MAX = CNT_W'(WCLK_HIGH_MAX_CYC);
	localparam logic [CNT_W-1:0] HOLD_RESET = '0;

	typedef struct packed {
		logic [RAM_DEPTH-1:0] lut_f;
		logic [RAM_DEPTH-1:0] lut_g;
		logic wclk_prev;
		logic [CNT_W-1:0] hold_cnt;
		logic overlong;
		logic we_prev;
		logic [RAM_ADDR_W:0] addr_prev;
		logic hazard;
		logic write_ack;
	} state_t;

	// Contents come up as after configuration; reset never reaches them
	state_t st_q = '{lut_f: INIT_F, lut_g: INIT_G, wclk_prev: WCLK_PREV_RESET, hold_cnt: HOLD_RESET,
		overlong: FLAG_RESET, we_prev: FLAG_RESET, addr_prev: '0, hazard: FLAG_RESET, write_ack: FLAG_RESET};
	state_t st_d;

	logic [RAM_ADDR_W-1:0] addr_lo;
	logic addr_hi;
	logic wclk_rise;
	logic mode_dual;

	assign addr_lo = i_addr[RAM_ADDR_W-1:0];
	assign addr_hi = i_addr[RAM_ADDR_W];
	assign mode_dual = (i_mode == MODE_DUAL_EDGE);
	// Active edge of the write clock, seen as a rise between two samples
	assign wclk_rise = i_wclk & ~st_q.wclk_prev;

	always_comb begin
		st_d = st_q;
		st_d.write_ack = 1'b0;
		st_d.wclk_prev = i_wclk;
		st_d.we_prev = i_we;
		st_d.addr_prev = i_addr;
		if (!i_rst_n) begin
			// Only control state is reset; both tables keep their bits
			st_d.wclk_prev = WCLK_PREV_RESET;
			st_d.hold_cnt = HOLD_RESET;
			st_d.overlong = FLAG_RESET;
			st_d.we_prev = FLAG_RESET;
			st_d.addr_prev = '0;
			st_d.hazard = FLAG_RESET;
			st_d.write_ack = FLAG_RESET;
		end else if (i_config_load) begin
			// Configuration is the only path that restores initial contents
			st_d.lut_f = INIT_F;
			st_d.lut_g = INIT_G;
		end else begin
			case (i_mode)
				MODE_DUAL_EDGE: begin
					// Writes only on the rising write clock with strobe high
					if (wclk_rise && i_we) begin
						// One data bit lands in both copies at the shared address
						st_d.lut_f[addr_lo] = i_data_in_pin_a;
						st_d.lut_g[addr_lo] = i_data_in_pin_a;
						st_d.write_ack = 1'b1;
					end
				end
				MODE_LEVEL_16X2: begin
					// Transparent while strobe is high; last sample before the fall wins
					if (i_we) begin
						st_d.lut_f[addr_lo] = i_data_in_pin_a;
						st_d.lut_g[addr_lo] = i_data_in_pin_b;
						st_d.write_ack = 1'b1;
					end
				end
				MODE_LEVEL_32X1: begin
					// Top address bit picks the table, so 32 entries of one bit
					if (i_we) begin
						if (addr_hi) begin
							st_d.lut_g[addr_lo] = i_data_in_pin_a;
						end else begin
							st_d.lut_f[addr_lo] = i_data_in_pin_a;
						end
						st_d.write_ack = 1'b1;
					end
				end
				default: begin
				end
			endcase
			// A stopped write clock after an edge can draw excess current; flag it sticky
			if (mode_dual && i_wclk) begin
				if (st_q.hold_cnt != HOLD_MAX) begin
					st_d.hold_cnt = st_q.hold_cnt + 1'b1;
				end else begin
					st_d.overlong = 1'b1;
				end
			end else begin
				st_d.hold_cnt = HOLD_RESET;
			end
			// An address moving under a level strobe writes spurious data; flag it sticky
			if (!mode_dual && i_we && st_q.we_prev && (i_addr != st_q.addr_prev)) begin
				st_d.hazard = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		st_q <= st_d;
	end

	// Reads are pure lookups so a same-cycle write shows on the next cycle
	always_comb begin
		if (i_mode == MODE_LEVEL_32X1) begin
			o_single_port_read_out = addr_hi ? st_q.lut_g[addr_lo] : st_q.lut_f[addr_lo];
		end else begin
			o_single_port_read_out = st_q.lut_f[addr_lo];
		end
		o_dual_port_read_out = st_q.lut_g[i_second_read_address];
	end

	assign o_write_ack = st_q.write_ack;
	assign o_wclk_overlong = st_q.overlong;
	assign o_level_addr_hazard = st_q.hazard;

	// Checks on the design's own behaviour
	logic wr_dual;
	assign wr_dual = i_rst_n && !i_config_load && mode_dual && wclk_rise && i_we;

	dual_write_both_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		wr_dual |=> (st_q.lut_f[$past(addr_lo)] == $past(i_data_in_pin_a))
			&& (st_q.lut_g[$past(addr_lo)] == $past(i_data_in_pin_a)) && o_write_ack)
		else $error("dual-port write did not reach both tables");

	copies_stay_equal_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(mode_dual && !i_config_load && st_q.lut_f == st_q.lut_g) |=> st_q.lut_f == st_q.lut_g)
		else $error("dual-port copies diverged");

	no_write_off_edge_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(mode_dual && !i_config_load && !(wclk_rise && i_we)) |=> $stable(st_q.lut_f) && $stable(st_q.lut_g)
			&& !o_write_ack)
		else $error("dual-port contents changed without a write clock edge");

	spo_after_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		wr_dual ##1 (mode_dual && $stable(addr_lo)) |-> o_single_port_read_out == $past(i_data_in_pin_a))
		else $error("single-port output missed the written bit");

	dpo_same_addr_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		wr_dual ##1 (i_second_read_address == $past(addr_lo)) |-> o_dual_port_read_out == $past(i_data_in_pin_a))
		else $error("dual-port output missed the written bit");

	level_16x2_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_mode == MODE_LEVEL_16X2 && i_we && !i_config_load) |=> (st_q.lut_f[$past(addr_lo)] == $past(i_data_in_pin_a))
			&& (st_q.lut_g[$past(addr_lo)] == $past(i_data_in_pin_b)))
		else $error("level write of 16x2 failed");

	level_32x1_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_mode == MODE_LEVEL_32X1 && i_we && !i_config_load && addr_hi) |=>
			(st_q.lut_g[$past(addr_lo)] == $past(i_data_in_pin_a)) && $stable(st_q.lut_f))
		else $error("level write of 32x1 upper half failed");

	config_load_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_config_load |=> st_q.lut_f == INIT_F && st_q.lut_g == INIT_G)
		else $error("configuration did not restore initial contents");

	reset_keeps_a: assert property (@(posedge i_clk_sys) disable iff (1'b0)
		(!i_rst_n && !i_config_load) |=> $stable(st_q.lut_f) && $stable(st_q.lut_g))
		else $error("reset disturbed the contents");

	ack_strobe_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(mode_dual && wclk_rise && !i_we) |=> !o_write_ack)
		else $error("write taken without strobe");

	// A write clock that stays high must not be taken as a fresh edge
	wclk_held_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(mode_dual && !i_config_load && i_wclk && st_q.wclk_prev) |=> !o_write_ack)
		else $error("held write clock wrote again");

	// A write clock already high at reset release is not an edge
	release_no_edge_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(!$past(i_rst_n) && mode_dual && i_wclk) |=> !o_write_ack)
		else $error("write taken on the edge after reset release");

	level_ack_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		((i_mode == MODE_LEVEL_16X2 || i_mode == MODE_LEVEL_32X1) && i_we && !i_config_load) |=> o_write_ack)
		else $error("level write not acknowledged");

	level_no_we_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		((i_mode == MODE_LEVEL_16X2 || i_mode == MODE_LEVEL_32X1) && !i_we && !i_config_load) |=>
			$stable(st_q.lut_f) && $stable(st_q.lut_g) && !o_write_ack)
		else $error("level contents changed without strobe");

	level_32x1_low_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_mode == MODE_LEVEL_32X1 && i_we && !i_config_load && !addr_hi) |=>
			(st_q.lut_f[$past(addr_lo)] == $past(i_data_in_pin_a)) && $stable(st_q.lut_g))
		else $error("level write of 32x1 lower half failed");

	spo_32x1_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_mode == MODE_LEVEL_32X1 && i_we && !i_config_load) ##1 (i_mode == MODE_LEVEL_32X1 && $stable(i_addr))
			|-> o_single_port_read_out == $past(i_data_in_pin_a))
		else $error("32x1 read missed the written bit");

	dpo_16x2_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_mode == MODE_LEVEL_16X2 && i_we && !i_config_load) ##1 (i_second_read_address == $past(addr_lo))
			|-> o_dual_port_read_out == $past(i_data_in_pin_b))
		else $error("16x2 second bit missed on dual-port output");

	idle_no_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_mode == MODE_IDLE && !i_config_load) |=> $stable(st_q.lut_f) && $stable(st_q.lut_g) && !o_write_ack)
		else $error("idle form changed the contents");

	// Configuration outranks any write presented with it
	config_first_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_config_load && i_we) |=> !o_write_ack)
		else $error("write taken during configuration");

	reset_flags_a: assert property (@(posedge i_clk_sys) disable iff (1'b0)
		!i_rst_n |=> !o_write_ack && !o_wclk_overlong && !o_level_addr_hazard)
		else $error("reset left a flag standing");

	// Bounded counter: a wrap would hide a stopped write clock
	hold_bound_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		st_q.hold_cnt <= HOLD_MAX)
		else $error("write clock counter ran past its limit");

	overlong_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(mode_dual && i_wclk && !i_config_load && st_q.hold_cnt == HOLD_MAX) |=> o_wclk_overlong)
		else $error("stopped write clock not flagged");

	overlong_sticky_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_wclk_overlong |=> o_wclk_overlong)
		else $error("overlong flag dropped without reset");

	hazard_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		($past(i_rst_n) && !mode_dual && !i_config_load && i_we && $past(i_we) && i_addr != $past(i_addr))
			|=> o_level_addr_hazard)
		else $error("address moved under strobe without a flag");

	hazard_sticky_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_level_addr_hazard |=> o_level_addr_hazard)
		else $error("hazard flag dropped without reset");

	no_false_hazard_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(!o_level_addr_hazard && (mode_dual || !i_we)) |=> !o_level_addr_hazard)
		else $error("hazard flag set without a held strobe");

	same_addr_rw_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		wr_dual && (i_second_read_address == addr_lo));
	level_write_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_mode == MODE_LEVEL_16X2 && i_we [*3]);
	upper_half_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_mode == MODE_LEVEL_32X1 && i_we && addr_hi);
	config_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_config_load ##1 wr_dual);
	hazard_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!o_level_addr_hazard ##1 o_level_addr_hazard);

endmodule

`default_nettype wire

// file: bench/wr_driver.sv
// Model of the user logic that drives the RAM write side
`timescale 1ns/1ps
`default_nettype none
module wr_driver
	import lut_ram_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_go,
	input wire logic i_level,
	input wire logic i_hold,
	input wire logic [RAM_ADDR_W:0] i_a,
	input wire logic i_da,
	input wire logic i_db,
	output logic [RAM_ADDR_W:0] o_addr,
	output logic o_da,
	output logic o_db,
	output logic o_we,
	output logic o_wclk
);
	logic [1:0] st = 2'h0;
	initial {o_addr, o_da, o_db, o_we, o_wclk} = '0;
	always @(posedge i_clk_sys) begin
		if (i_go && st == 2'h0) begin
			{o_da, o_db} <= {i_da, i_db};
			o_we <= 1'b1;
			st <= i_level ? 2'h2 : 2'h1;
		end else if (st == 2'h1) begin
			o_wclk <= 1'b1;
			st <= 2'h2;
		end else if (st == 2'h2 && !i_hold) begin
			// One cycle high, so strobe ends before the next edge
			{o_we, o_wclk} <= 2'h0;
			// Stale data is inverted so a late sample cannot pass
			{o_da, o_db} <= ~{o_da, o_db};
			st <= 2'h0;
		end else if (st == 2'h2) begin
			o_addr <= i_a; // Held strobe lets the address move, to provoke the hazard
		end else if (st == 2'h0) begin
			o_addr <= i_a; // Address moves here with strobe low; a held strobe also lets it move
		end
	end
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the logic cell RAM
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import lut_ram_pkg::*;
	localparam logic [15:0] F0 = 16'h3C5A;
	localparam logic [15:0] G0 = 16'hA50F;
	logic clk_sys = 1'b0, rst_n = 1'b0, config_load = 1'b0, go = 1'b0, lvl = 1'b0, hold = 1'b0;
	logic p_da = 1'b0, p_db = 1'b0, da, db, we, wclk, single_port_read_out, dual_port_read_out, ack, overlong, haz, d, got;
	ram_mode_t mode = MODE_DUAL_EDGE;
	logic [RAM_ADDR_W:0] p_a = '0, addr;
	logic [RAM_ADDR_W-1:0] sra = '0;
	logic [15:0] ef = F0, eg = G0;
	int n_mismatch = 0, n_compared = 0;
	distributed_lut_ram #(.INIT_F(F0), .INIT_G(G0), .WCLK_HIGH_MAX_CYC(8)) dut (.i_clk_sys(clk_sys),
		.i_rst_n(rst_n), .i_config_load(config_load), .i_mode(mode), .i_addr(addr),
		.i_second_read_address(sra), .i_data_in_pin_a(da), .i_data_in_pin_b(db), .i_we(we), .i_wclk(wclk),
		.o_single_port_read_out(single_port_read_out), .o_dual_port_read_out(dual_port_read_out), .o_write_ack(ack),
		.o_wclk_overlong(overlong), .o_level_addr_hazard(haz));
	wr_driver drv (.i_clk_sys(clk_sys), .i_go(go), .i_level(lvl), .i_hold(hold), .i_a(p_a), .i_da(p_da),
		.i_db(p_db), .o_addr(addr), .o_da(da), .o_db(db), .o_we(we), .o_wclk(wclk));
	initial forever #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic g, input logic e, input string msg);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	// Long holds keep the write clock high on purpose
	task automatic wr(input ram_mode_t m, input logic [4:0] ad, input logic a, input logic b, input int h);
		@(posedge clk_sys);
		mode <= m;
		lvl <= (m == MODE_LEVEL_16X2 || m == MODE_LEVEL_32X1);
		{p_a, p_da, p_db, hold} <= {ad, a, b, h != 0};
		@(posedge clk_sys);
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		got = 1'b0;
		for (int n = 0; n < h + 6; n++) begin
			@(posedge clk_sys);
			if (n == h) hold <= 1'b0;
			#1;
			if (ack === 1'b1) got = 1'b1;
		end
	endtask
	// Strobe held while the address moves from 1 to 2; both get the data
	task automatic haz_wr();
		@(posedge clk_sys);
		mode <= MODE_LEVEL_16X2;
		lvl <= 1'b1;
		{p_a, p_da, p_db, hold} <= {5'h01, 1'b1, 1'b0, 1'b1};
		@(posedge clk_sys);
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		repeat (2) @(posedge clk_sys);
		p_a <= 5'h02;
		repeat (2) @(posedge clk_sys);
		hold <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	// Second read address differs from the shared one to show independence
	task automatic chk_all();
		for (int a = 0; a < RAM_DEPTH; a++) begin
			@(posedge clk_sys);
			p_a <= {1'b0, 4'(a)};
			sra <= 4'(a ^ 5);
			repeat (2) @(posedge clk_sys);
			#1;
			chk(single_port_read_out, ef[a], "single port read");
			chk(dual_port_read_out, eg[a ^ 5], "dual port read");
		end
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		chk_all();
		for (int a = 0; a < RAM_DEPTH; a++) begin
			d = a[0] ^ a[2];
			sra <= 4'(a);
			wr(MODE_DUAL_EDGE, 5'(a), d, ~d, 0);
			chk(got, 1'b1, "dual write ack");
			chk(dual_port_read_out, d, "read at write address");
			ef[a] = d;
			eg[a] = d;
		end
		chk_all();
		wr(MODE_IDLE, 5'h07, ~ef[7], 1'b0, 0);
		chk(got, 1'b0, "idle write refused");
		wr(MODE_LEVEL_16X2, 5'h03, ef[3], ~eg[3], 0);
		chk(got, 1'b1, "16x2 write ack");
		eg[3] = ~eg[3];
		wr(MODE_LEVEL_32X1, 5'h19, ~eg[9], 1'b0, 0);
		eg[9] = ~eg[9];
		chk_all();
		wr(MODE_DUAL_EDGE, 5'h00, ~ef[0], 1'b0, 12);
		ef[0] = ~ef[0];
		eg[0] = ef[0];
		chk(overlong, 1'b1, "long write clock flagged");
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		chk(overlong, 1'b0, "flag cleared by reset");
		chk_all();
		@(posedge clk_sys);
		config_load <= 1'b1;
		@(posedge clk_sys);
		config_load <= 1'b0;
		{ef, eg} = {F0, G0};
		chk_all();
		chk(haz, 1'b0, "no hazard with settled address");
		haz_wr();
		chk(haz, 1'b1, "address moved under strobe");
		{ef[1], ef[2], eg[1], eg[2]} = 4'hC;
		chk_all();
		end_sim();
	end
	initial begin
		#200000;
		n_mismatch++;
		end_sim();
	end
endmodule
`default_nettype wire
